// File: reset_park_pkg.sv
/*
 * Constants shared by the reset and park input control block.
 * Assumes a single 200 MHz system clock.
 */
package reset_park_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLOCK_PERIOD_PS = 5000;
    localparam int STRAP_DELAY_US_X10 = 15;
    localparam int STRAP_DELAY_CYCLES = (STRAP_DELAY_US_X10 * 100000) / CLOCK_PERIOD_PS;
    localparam int STRAP_COUNT_WIDTH = 10;
    localparam int INIT_CYCLES = 16;

    // ------------------------------------------------------------
    // Pin groups
    // ------------------------------------------------------------
    localparam int LIGHT_SELECT_WIDTH = 4;
    localparam int STRAP_WIDTH = 3;
    localparam int TRISTATE_WIDTH = 8;
    localparam int SYNC_STAGES = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [STRAP_WIDTH-1:0] STRAP_RESET = 3'h0;
    localparam logic PARK_RESET = 1'h1;

    typedef enum logic [2:0] {
        PHASE_RESET,
        PHASE_STRAP_WAIT,
        PHASE_INIT,
        PHASE_RUN
    } phase_t;

endpackage

// File: level_sync.sv
/*
 * Two-stage synchroniser for one level.
 * Assumes the input may change at any time relative to clock.
 */
module level_sync
    import reset_park_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_b,
    // Level in and out
    input wire logic asyncIn,
    output logic syncOut
);

    logic firstStage_reg;
    logic secondStage_reg;

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            firstStage_reg <= 1'h0;
            secondStage_reg <= 1'h0;
        end else begin
            firstStage_reg <= asyncIn;
            secondStage_reg <= firstStage_reg;
        end
    end

    assign syncOut = secondStage_reg;

endmodule

// File: reset_park_control.sv
/*
 * Power-on reset and mirror park input control.
 * Assumes clock runs at 200 MHz and the power partner drives the park input.
 */
// Notes on behaviour
// - Power-on reset input is active low; low holds reset, high runs.
// - Rising edge of reset input starts self-configuration and initialization.
// - In reset, light selects, drive enable and converter clock/data are driven low.
// - In reset, all other outputs and bidirectional pins are tristated.
// - Park request input low asks to park, high asks un-park.
// - Strap pins tristated in reset, sampled about 1.5us after release.
module reset_park_control
    import reset_park_pkg::*;
(
    // Clock and synchronous reset
    input wire logic clock,
    input wire logic rst_b,
    // Pins from the board
    input wire logic power_on_rst_n,
    input wire logic park_request_n,
    // Strap pins, two-way
    input wire logic [STRAP_WIDTH-1:0] strapIn,
    output logic [STRAP_WIDTH-1:0] strapOut,
    output logic [STRAP_WIDTH-1:0] strapOe,
    // Functional values from the core
    input wire logic [LIGHT_SELECT_WIDTH-1:0] coreLightSelect,
    input wire logic coreDriveEnable,
    input wire logic coreConvClock,
    input wire logic coreConvData,
    input wire logic [TRISTATE_WIDTH-1:0] coreOut,
    input wire logic [TRISTATE_WIDTH-1:0] coreOe,
    // Pins driven low in reset
    output logic [LIGHT_SELECT_WIDTH-1:0] lightSourceSelect,
    output logic mirror_array_drive_enable_n,
    output logic monitor_converter_clock,
    output logic monitor_converter_serial_out,
    // Other outputs, tristated in reset
    output logic [TRISTATE_WIDTH-1:0] pinOut,
    output logic [TRISTATE_WIDTH-1:0] pinOe,
    // Status to the core
    output logic [STRAP_WIDTH-1:0] strapValue,
    output logic strapValid,
    output logic initStart,
    output logic running,
    output logic parkRequest
);

    // ------------------------------------------------------------
    // Synchronisers
    // ------------------------------------------------------------
    logic resetSync;
    logic parkSync;

    // Both synchronisers clear low, so until real pin levels arrive the
    // block reads the reset pin as held and the park pin as asking to park.
    level_sync resetSyncInst (
        .clock(clock),
        .rst_b(rst_b),
        .asyncIn(power_on_rst_n),
        .syncOut(resetSync)
    );

    level_sync parkSyncInst (
        .clock(clock),
        .rst_b(rst_b),
        .asyncIn(park_request_n),
        .syncOut(parkSync)
    );

    // ------------------------------------------------------------
    // Phase sequencing
    // ------------------------------------------------------------
    phase_t phase_reg;
    phase_t phase_next;
    logic [STRAP_COUNT_WIDTH-1:0] count_reg;
    logic [STRAP_COUNT_WIDTH-1:0] count_next;
    logic [STRAP_WIDTH-1:0] strap_reg;
    logic [STRAP_WIDTH-1:0] strap_next;
    logic init_reg;
    logic park_reg;
    logic run_reg;
    logic inReset;
    logic strapDone;
    logic initDone;
    logic leavingReset;
    logic inInitOrRun;

    // A low synchronised reset input holds the sequencer in reset.
    assign inReset = !resetSync;
    // Strap wait and init end on their last count, so each phase lasts its full count.
    assign strapDone = (count_reg == STRAP_COUNT_WIDTH'(STRAP_DELAY_CYCLES - 1));
    assign initDone = (count_reg == STRAP_COUNT_WIDTH'(INIT_CYCLES - 1));
    assign leavingReset = (phase_reg == PHASE_RESET) && !inReset;
    assign inInitOrRun = (phase_reg == PHASE_INIT) || (phase_reg == PHASE_RUN);

    // A low reset input overrides every phase and clears the counter.
    always_comb begin
        phase_next = phase_reg;
        count_next = count_reg + 1'h1;
        strap_next = strap_reg;
        if (inReset) begin
            phase_next = PHASE_RESET;
            count_next = '0;
        end else begin
            case (phase_reg)
                PHASE_RESET: begin
                    phase_next = PHASE_STRAP_WAIT;
                    count_next = '0;
                end
                PHASE_STRAP_WAIT: begin
                    if (strapDone) begin
                        strap_next = strapIn;
                        phase_next = PHASE_INIT;
                        count_next = '0;
                    end
                end
                PHASE_INIT: begin
                    if (initDone) begin
                        phase_next = PHASE_RUN;
                    end
                end
                PHASE_RUN: begin
                    // The counter stands still here so it cannot wrap into a stray match.
                    count_next = count_reg;
                end
                default: begin
                    phase_next = PHASE_RESET;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            phase_reg <= PHASE_RESET;
        end else begin
            phase_reg <= phase_next;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            count_reg <= '0;
        end else begin
            count_reg <= count_next;
        end
    end

    // Captured straps survive a later pin reset until the next sample.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            strap_reg <= STRAP_RESET;
        end else begin
            strap_reg <= strap_next;
        end
    end

    // One-cycle start pulse as the sequencer leaves reset.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            init_reg <= 1'h0;
        end else begin
            init_reg <= leavingReset;
        end
    end

    // Running follows the next phase, so it drops one edge after reset is seen.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            run_reg <= 1'h0;
        end else begin
            run_reg <= (phase_next == PHASE_RUN);
        end
    end

    // Park level after the synchroniser; a high here asks to park.
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            park_reg <= PARK_RESET;
        end else begin
            park_reg <= !parkSync;
        end
    end

    // ------------------------------------------------------------
    // Pin control
    // ------------------------------------------------------------
    logic pinsActive;

    // Outputs are released only once the sequencer has left reset.
    assign pinsActive = (phase_reg != PHASE_RESET) && !inReset;

    // Functional values pass only outside reset; otherwise forced low.
    assign lightSourceSelect = pinsActive ? coreLightSelect : '0;
    assign mirror_array_drive_enable_n = pinsActive ? coreDriveEnable : 1'h0;
    assign monitor_converter_clock = pinsActive ? coreConvClock : 1'h0;
    assign monitor_converter_serial_out = pinsActive ? coreConvData : 1'h0;

    // Only the enable is gated, so these pins float in reset whatever the core drives.
    assign pinOut = coreOut;
    assign pinOe = pinsActive ? coreOe : '0;

    // Straps are inputs until sampled; they are never driven here.
    assign strapOut = '0;
    assign strapOe = '0;

    // ------------------------------------------------------------
    // Status to the core
    // ------------------------------------------------------------
    // The strap value is valid from its capture until the reset pin falls again.
    assign strapValue = strap_reg;
    assign strapValid = inInitOrRun;
    assign initStart = init_reg;
    assign running = run_reg;
    assign parkRequest = park_reg;

endmodule

// File: reset_park_props.sv
/*
 * Checker on the ports of the reset and park control block.
 * Assumes one clock and inputs that change away from the rising edge.
 */
module reset_park_props
    import reset_park_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic power_on_rst_n,
    input wire logic park_request_n,
    input wire logic [STRAP_WIDTH-1:0] strapOe,
    input wire logic [LIGHT_SELECT_WIDTH-1:0] coreLightSelect,
    input wire logic [TRISTATE_WIDTH-1:0] coreOe,
    input wire logic [LIGHT_SELECT_WIDTH-1:0] lightSourceSelect,
    input wire logic mirror_array_drive_enable_n,
    input wire logic monitor_converter_clock,
    input wire logic monitor_converter_serial_out,
    input wire logic [TRISTATE_WIDTH-1:0] pinOe,
    input wire logic [STRAP_WIDTH-1:0] strapValue,
    input wire logic strapValid,
    input wire logic initStart,
    input wire logic running,
    input wire logic parkRequest
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    logic [3:0] lowCnt;
    logic [3:0] upCnt;
    always_ff @(posedge clock) begin
        lowCnt <= (!rst_b || power_on_rst_n) ? 4'h0 : lowCnt + {3'h0, lowCnt != 4'hF};
        upCnt <= !rst_b ? 4'h0 : upCnt + {3'h0, upCnt != 4'hF};
    end
    sequence s_strapWait;
        ##300 $rose(strapValid);
    endsequence
    a_forced_low_pins: assert property (lowCnt > 4'h4 |-> !running && pinOe == 8'h00 &&
        {lightSourceSelect, mirror_array_drive_enable_n, monitor_converter_clock,
        monitor_converter_serial_out} == 7'h00) else $error("pins not low in reset");
    a_straps_undriven: assert property (strapOe == 3'h0) else $error("strap driven");
    a_init_pulse: assert property (initStart |=> !initStart) else $error("long init");
    a_strap_delay: assert property (initStart |-> s_strapWait) else $error("strap time");
    a_run_after_init: assert property ($rose(running) |-> $past(strapValid, 16) &&
        !$past(strapValid, 17)) else $error("run time");
    a_park_follows: assert property (upCnt > 4'h4 |->
        parkRequest == !$past(park_request_n, 3)) else $error("park level");
    a_start_synced: assert property ($rose(initStart) |-> $past(power_on_rst_n, 3) &&
        $past(power_on_rst_n, 2)) else $error("start early");
    a_core_passed: assert property (running && $past(power_on_rst_n, 2) |->
        pinOe == coreOe &&
        lightSourceSelect == coreLightSelect) else $error("core not passed");
    a_strap_held: assert property (strapValid && $past(strapValid) |->
        $stable(strapValue)) else $error("strap changed");
endmodule
bind reset_park_control reset_park_props i_props (.*);

// File: power_partner_model.sv
/*
 * Power partner: drives the reset and park pins.
 * Assumes the bench drives its controls at the falling clock edge.
 */
module power_partner_model (
    // Controls from the bench
    input wire logic supplyOk,
    input wire logic lossWarn,
    // Pins to the block
    output logic power_on_rst_n,
    output logic park_request_n
);
    timeunit 1ns;
    timeprecision 100ps;
    assign power_on_rst_n = supplyOk;
    assign park_request_n = !lossWarn;
endmodule

// File: reset_and_park_input_control_tb.sv
/*
 * Self-checking bench for the reset and park control block.
 * Assumes the checker is bound to the block by its own file.
 */
module reset_and_park_input_control_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import reset_park_pkg::*;
    logic clock = 0, rst_b = 0, supplyOk = 0, lossWarn = 0, pwr, park, drv, cc, cd, ld, lc, lo;
    logic [2:0] strapIn = 3'h5, sv, so, soe;
    logic [3:0] cls = 4'hA, ls;
    logic [7:0] co = 8'h5A, ce = 8'hFF, po, pe;
    logic svld, ist, run, prq;
    int numErrors = 0, compares = 0, n;
    always #2.5 clock = ~clock;
    power_partner_model i_model (.supplyOk(supplyOk), .lossWarn(lossWarn),
        .power_on_rst_n(pwr), .park_request_n(park));
    reset_park_control i_dut (.clock(clock), .rst_b(rst_b), .power_on_rst_n(pwr),
        .park_request_n(park), .strapIn(strapIn), .strapOut(so), .strapOe(soe), .coreLightSelect(cls),
        .coreDriveEnable(drv), .coreConvClock(cc), .coreConvData(cd), .coreOut(co), .coreOe(ce),
        .lightSourceSelect(ls), .mirror_array_drive_enable_n(ld), .monitor_converter_clock(lc),
        .monitor_converter_serial_out(lo), .pinOut(po), .pinOe(pe), .strapValue(sv),
        .strapValid(svld), .initStart(ist), .running(run), .parkRequest(prq));
    task check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            numErrors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task cyc(input int k);
        repeat (k) @(negedge clock);
    endtask
    task give_verdict;
        $display("compares %0d numErrors %0d", compares, numErrors);
        if (numErrors == 0 && compares > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task test_low;
        cyc(6);
        check({ls, ld, lc, lo, pe, run}, 32'h0);
        check({so, soe}, 32'h0);
    endtask
    task test_start;
        n = 0;
        supplyOk = 1;
        while (ist !== 1'b1 && n < 50) begin cyc(1); n++; end
        check(ist, 32'h1);
        n = 0;
        while (svld !== 1'b1 && n < 400) begin cyc(1); n++; end
        check(n, STRAP_DELAY_CYCLES);
        check(sv, 32'h5);
        n = 0;
        while (run !== 1'b1 && n < 50) begin cyc(1); n++; end
        check(n, INIT_CYCLES);
        strapIn = 3'h2;
        cls = 4'h6;
        {drv, cc, cd, co, ce} = {3'h5, 8'hC3, 8'h0F};
        cyc(2);
        check({sv, ls, ld, lc, lo, po, pe}, {3'h5, 4'h6, 3'h5, 8'hC3, 8'h0F});
    endtask
    task test_park;
        lossWarn = 1;
        cyc(2);
        check(prq, 32'h0);
        cyc(1);
        check(prq, 32'h1);
        lossWarn = 0;
        cyc(3);
        check(prq, 32'h0);
    endtask
    initial begin
        {drv, cc, cd} = 3'h7;
        cyc(8);
        rst_b = 1;
        test_low;
        test_start;
        test_park;
        supplyOk = 0;
        test_low;
        give_verdict;
    end
    initial begin
        #(5 * 3000);
        numErrors++;
        give_verdict;
    end
endmodule
